/* design/clcd_pkg.sv */
package clcd_pkg;

    // Slave address: five fixed upper bits, two strap bits below
    localparam logic [4:0] ADDR_FIXED   = 5'h0F;
    localparam int         ADDR_MSB     = 7;
    localparam int         ADDR_RW_BIT  = 0;

    // Control byte layout
    localparam int         CTRL_CONT_BIT = 7;
    localparam int         CTRL_SEL_BIT  = 6;

    // Bits per byte before the acknowledge pulse
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // Display data RAM
    localparam int         RAM_AW       = 7;
    localparam int         RAM_DEPTH    = 128;
    localparam logic [6:0] RAM_LAST     = 7'h7F;
    localparam logic [7:0] BLANK_CODE   = 8'h20;
    localparam logic [6:0] PTR_ZERO     = 7'h00;
    localparam logic [6:0] PTR_STEP     = 7'h01;

    // Values after power-on initialisation
    localparam logic RST_DATA_LENGTH = 1'b1;
    localparam logic RST_LINE_COUNT  = 1'b0;
    localparam logic RST_FONT        = 1'b0;
    localparam logic RST_DISPLAY_ON  = 1'b0;
    localparam logic RST_CURSOR_ON   = 1'b0;
    localparam logic RST_BLINK_ON    = 1'b0;
    localparam logic RST_INCREMENT   = 1'b1;
    localparam logic RST_SHIFT       = 1'b0;

    // Instruction opcode bit positions (highest set bit selects)
    localparam int OP_SET_DDR   = 7;
    localparam int OP_SET_GLYPH = 6;
    localparam int OP_FUNC      = 5;
    localparam int OP_SHIFT     = 4;
    localparam int OP_DISP      = 3;
    localparam int OP_ENTRY     = 2;
    localparam int OP_HOME      = 1;
    localparam int OP_CLEAR     = 0;

    // Link-side receive states
    typedef enum logic [1:0] {
        L_IDLE   = 2'b00,
        L_RECV   = 2'b01,
        L_ACK    = 2'b10,
        L_IGNORE = 2'b11
    } clcd_lstate_t;

    // Position of the next byte within a transfer
    typedef enum logic [1:0] {
        PH_ADDR   = 2'b00,
        PH_CTRL   = 2'b01,
        PH_DATA   = 2'b10,
        PH_STREAM = 2'b11
    } clcd_phase_t;

    // Core states
    typedef enum logic [1:0] {
        C_INIT  = 2'b00,
        C_READY = 2'b01,
        C_CLEAR = 2'b10
    } clcd_cstate_t;

endpackage : clcd_pkg

/* design/clcd_sync.sv */
`timescale 1ns/1ps
// Two-stage synchroniser; the first stage feeds only the second
module clcd_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,     // Destination clock
    input  wire logic         arst_n,  // Asynchronous reset, active low
    input  wire logic [W-1:0] d,       // Asynchronous input
    output logic      [W-1:0] q        // Synchronised output
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } clcd_sync_t;

    clcd_sync_t r;
    clcd_sync_t next_r;

    // Shift chain
    always_comb begin
        next_r    = r;
        next_r.s1 = d;
        next_r.s2 = r.s1;
    end

    // Reset to a constant only
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign q = r.s2;

endmodule : clcd_sync

/* design/clcd_i2c_slave.sv */
`timescale 1ns/1ps
module clcd_i2c_slave (
    input  wire logic       REF_CLK,              // Core clock, 40 MHz
    input  wire logic       ARST_N,               // Asynchronous reset, active low
    input  wire logic       LINK_CLK,             // Line sampling clock
    input  wire logic       SCL_I,                // Serial clock line level
    input  wire logic       SDA_I,                // Serial data line level
    output logic            SDA_O,                // Serial data drive value
    output logic            SDA_OE,               // Serial data drive enable
    input  wire logic       ADDR_SELECT_PIN_LOW,  // Address strap, bit 0
    input  wire logic       ADDR_SELECT_PIN_HIGH, // Address strap, bit 1
    input  wire logic [6:0] DISP_RD_ADDR,         // Display refresh read address
    output logic      [7:0] DISP_RD_DATA,         // Display refresh read data
    output logic            BUSY_FLAG,            // Internal operation running
    output logic      [6:0] ADDRESS_COUNTER,      // RAM address pointer
    output logic            DATA_LENGTH_BIT,      // Interface length setting
    output logic            LINE_COUNT,           // Two-line mode
    output logic            FONT,                 // Tall font
    output logic            DISPLAY_ON,           // Display enable
    output logic            CURSOR_ON,            // Cursor enable
    output logic            BLINK_ON,             // Blink enable
    output logic            ENTRY_INCREMENT,      // Counter direction
    output logic            ENTRY_SHIFT           // Whole-display shift
);

    // Reset copies released through two flops in each domain
    logic       core_rst_n;
    logic       link_rst_n;
    logic [3:0] link_pins;
    logic       tog_core;

    clcd_sync #(.W(1)) u_core_rst (
        .clk    (REF_CLK),
        .arst_n (ARST_N),
        .d      (1'b1),
        .q      (core_rst_n)
    );

    clcd_sync #(.W(1)) u_link_rst (
        .clk    (LINK_CLK),
        .arst_n (ARST_N),
        .d      (1'b1),
        .q      (link_rst_n)
    );

    // Lines and straps are asynchronous to the sampling clock
    clcd_sync #(.W(4)) u_link_pins (
        .clk    (LINK_CLK),
        .arst_n (link_rst_n),
        .d      ({SCL_I, SDA_I, ADDR_SELECT_PIN_HIGH, ADDR_SELECT_PIN_LOW}),
        .q      (link_pins)
    );

    // ------------------------------------------------------------------
    // Link domain: bit, byte and acknowledge handling
    // ------------------------------------------------------------------
    typedef struct packed {
        clcd_pkg::clcd_lstate_t st;
        clcd_pkg::clcd_phase_t  ph;
        logic [3:0]             cnt;
        logic [7:0]             shift;
        logic                   sel;
        logic                   ack;
        logic                   drive_val;
        logic                   scl_prev;
        logic                   sda_prev;
        logic [7:0]             byte_out;
        logic                   kind_out;
        logic                   tog;
    } clcd_link_t;

    clcd_link_t l;
    clcd_link_t next_l;
    logic       scl;
    logic       sda;
    logic       start_cond;
    logic       stop_cond;
    logic       scl_rise;
    logic       scl_fall;
    logic [6:0] own_addr;

    // Edges seen on synchronised copies only
    assign scl        = link_pins[3];
    assign sda        = link_pins[2];
    assign own_addr   = {clcd_pkg::ADDR_FIXED, link_pins[1:0]};
    assign start_cond = scl && l.scl_prev && l.sda_prev && !sda;
    assign stop_cond  = scl && l.scl_prev && !l.sda_prev && sda;
    assign scl_rise   = scl && !l.scl_prev;
    assign scl_fall   = !scl && l.scl_prev;

    // Receive sequencer; start and stop override any state
    always_comb begin
        next_l           = l;
        next_l.scl_prev  = scl;
        next_l.sda_prev  = sda;
        next_l.drive_val = 1'b0;
        if (start_cond) begin
            next_l.st  = clcd_pkg::L_RECV;
            next_l.ph  = clcd_pkg::PH_ADDR;
            next_l.cnt = '0;
            next_l.ack = 1'b0;
        end else if (stop_cond) begin
            next_l.st  = clcd_pkg::L_IDLE;
            next_l.ack = 1'b0;
        end else begin
            unique case (l.st)
                clcd_pkg::L_IDLE, clcd_pkg::L_IGNORE: begin
                    next_l.ack = 1'b0;
                end
                clcd_pkg::L_RECV: begin
                    // Sample at the rising edge, mid high phase is stable
                    if (scl_rise && (l.cnt < clcd_pkg::BITS_PER_BYTE)) begin
                        next_l.shift = {l.shift[6:0], sda};
                        next_l.cnt   = l.cnt + 4'h1;
                    end
                    // End of eighth pulse: decide the ninth
                    if (scl_fall && (l.cnt == clcd_pkg::BITS_PER_BYTE)) begin
                        next_l.st  = clcd_pkg::L_ACK;
                        next_l.ack = 1'b1;
                        unique case (l.ph)
                            clcd_pkg::PH_ADDR: begin
                                // Reads are refused, device never transmits
                                if (l.shift[clcd_pkg::ADDR_MSB:1] == own_addr &&
                                    !l.shift[clcd_pkg::ADDR_RW_BIT]) begin
                                    next_l.ph = clcd_pkg::PH_CTRL;
                                end else begin
                                    next_l.st  = clcd_pkg::L_IGNORE;
                                    next_l.ack = 1'b0;
                                end
                            end
                            clcd_pkg::PH_CTRL: begin
                                next_l.sel = l.shift[clcd_pkg::CTRL_SEL_BIT];
                                next_l.ph  = l.shift[clcd_pkg::CTRL_CONT_BIT] ?
                                             clcd_pkg::PH_DATA :
                                             clcd_pkg::PH_STREAM;
                            end
                            clcd_pkg::PH_DATA, clcd_pkg::PH_STREAM: begin
                                next_l.byte_out = l.shift;
                                next_l.kind_out = l.sel;
                                next_l.tog      = ~l.tog;
                                if (l.ph == clcd_pkg::PH_DATA) begin
                                    next_l.ph = clcd_pkg::PH_CTRL;
                                end
                            end
                        endcase
                    end
                end
                clcd_pkg::L_ACK: begin
                    // Release at the end of the ninth pulse
                    if (scl_fall) begin
                        next_l.ack = 1'b0;
                        next_l.cnt = '0;
                        next_l.st  = clcd_pkg::L_RECV;
                    end
                end
            endcase
        end
    end

    // Synchroniser starts low; a start needs both lines seen high first
    always_ff @(posedge LINK_CLK or negedge link_rst_n) begin
        if (!link_rst_n) begin
            l <= '0;
        end else begin
            l <= next_l;
        end
    end

    assign SDA_OE = l.ack;
    assign SDA_O  = l.drive_val;

    // ------------------------------------------------------------------
    // Core domain: byte intake, instructions, RAM, initialisation
    // ------------------------------------------------------------------

    // Byte and kind are held for a whole byte time, the toggle flags them
    clcd_sync #(.W(1)) u_tog (
        .clk    (REF_CLK),
        .arst_n (core_rst_n),
        .d      (l.tog),
        .q      (tog_core)
    );

    typedef struct packed {
        clcd_pkg::clcd_cstate_t st;
        logic [6:0]             fill;
        logic [6:0]             ptr;
        logic                   glyph_sel;
        logic                   tog_seen;
        logic                   busy;
        logic                   dlen;
        logic                   n;
        logic                   f;
        logic                   d;
        logic                   c;
        logic                   b;
        logic                   id;
        logic                   s;
    } clcd_core_t;

    localparam clcd_core_t CORE_RST = '{
        st:        clcd_pkg::C_INIT,
        fill:      clcd_pkg::PTR_ZERO,
        ptr:       clcd_pkg::PTR_ZERO,
        glyph_sel: 1'b0,
        tog_seen:  1'b0,
        busy:      1'b1,
        dlen:      clcd_pkg::RST_DATA_LENGTH,
        n:         clcd_pkg::RST_LINE_COUNT,
        f:         clcd_pkg::RST_FONT,
        d:         clcd_pkg::RST_DISPLAY_ON,
        c:         clcd_pkg::RST_CURSOR_ON,
        b:         clcd_pkg::RST_BLINK_ON,
        id:        clcd_pkg::RST_INCREMENT,
        s:         clcd_pkg::RST_SHIFT
    };

    clcd_core_t c;
    clcd_core_t next_c;
    logic       new_byte;
    logic [7:0] rx;
    logic       ram_we;
    logic [6:0] ram_wa;
    logic [7:0] ram_wd;
    logic [6:0] ptr_step;
    logic [7:0] dram [clcd_pkg::RAM_DEPTH];
    logic [7:0] rd_data;

    assign new_byte = tog_core != c.tog_seen;
    assign rx       = l.byte_out;
    assign ptr_step = c.id ? c.ptr + clcd_pkg::PTR_STEP : c.ptr - clcd_pkg::PTR_STEP;

    // Bytes arriving while busy are dropped; the host must wait
    always_comb begin
        next_c          = c;
        next_c.tog_seen = tog_core;
        ram_we          = 1'b0;
        ram_wa          = c.ptr;
        ram_wd          = rx;
        unique case (c.st)
            clcd_pkg::C_INIT, clcd_pkg::C_CLEAR: begin
                ram_we      = 1'b1;
                ram_wa      = c.fill;
                ram_wd      = clcd_pkg::BLANK_CODE;
                next_c.fill = c.fill + clcd_pkg::PTR_STEP;
                if (c.fill == clcd_pkg::RAM_LAST) begin
                    next_c.st = clcd_pkg::C_READY;
                end
            end
            clcd_pkg::C_READY: begin
                if (new_byte && l.kind_out) begin
                    // Glyph writes only move the pointer, no glyph store here
                    ram_we    = !c.glyph_sel;
                    next_c.ptr = ptr_step;
                end else if (new_byte) begin
                    if (rx[clcd_pkg::OP_SET_DDR]) begin
                        next_c.ptr       = rx[6:0];
                        next_c.glyph_sel = 1'b0;
                    end else if (rx[clcd_pkg::OP_SET_GLYPH]) begin
                        next_c.ptr       = {1'b0, rx[5:0]};
                        next_c.glyph_sel = 1'b1;
                    end else if (rx[clcd_pkg::OP_FUNC]) begin
                        next_c.dlen = rx[4];
                        next_c.n  = rx[3];
                        next_c.f  = rx[2];
                    end else if (rx[clcd_pkg::OP_SHIFT]) begin
                        if (!rx[3]) begin
                            next_c.ptr = rx[2] ? c.ptr + clcd_pkg::PTR_STEP :
                                                 c.ptr - clcd_pkg::PTR_STEP;
                        end
                    end else if (rx[clcd_pkg::OP_DISP]) begin
                        next_c.d = rx[2];
                        next_c.c = rx[1];
                        next_c.b = rx[0];
                    end else if (rx[clcd_pkg::OP_ENTRY]) begin
                        next_c.id = rx[1];
                        next_c.s  = rx[0];
                    end else if (rx[clcd_pkg::OP_HOME]) begin
                        next_c.ptr = clcd_pkg::PTR_ZERO;
                    end else if (rx[clcd_pkg::OP_CLEAR]) begin
                        next_c.st        = clcd_pkg::C_CLEAR;
                        next_c.fill      = clcd_pkg::PTR_ZERO;
                        next_c.ptr       = clcd_pkg::PTR_ZERO;
                        next_c.id        = clcd_pkg::RST_INCREMENT;
                        next_c.glyph_sel = 1'b0;
                    end
                end
            end
            default: begin
                next_c.st = clcd_pkg::C_READY;
            end
        endcase
        next_c.busy = next_c.st != clcd_pkg::C_READY;
    end

    // Power-on state comes from constants: settings and busy
    always_ff @(posedge REF_CLK or negedge core_rst_n) begin
        if (!core_rst_n) begin
            c <= CORE_RST;
        end else begin
            c <= next_c;
        end
    end

    // RAM array has no reset; init sequence clears it
    always_ff @(posedge REF_CLK) begin
        if (ram_we) begin
            dram[ram_wa] <= ram_wd;
        end
    end

    // Registered refresh read port
    always_ff @(posedge REF_CLK or negedge core_rst_n) begin
        if (!core_rst_n) begin
            rd_data <= clcd_pkg::BLANK_CODE;
        end else begin
            rd_data <= dram[DISP_RD_ADDR];
        end
    end

    assign DISP_RD_DATA    = rd_data;
    assign BUSY_FLAG       = c.busy;
    assign ADDRESS_COUNTER = c.ptr;
    assign DATA_LENGTH_BIT = c.dlen;
    assign LINE_COUNT      = c.n;
    assign FONT            = c.f;
    assign DISPLAY_ON      = c.d;
    assign CURSOR_ON       = c.c;
    assign BLINK_ON        = c.b;
    assign ENTRY_INCREMENT = c.id;
    assign ENTRY_SHIFT     = c.s;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_addr_match;
        @(posedge LINK_CLK) disable iff (!link_rst_n)
        (l.st == clcd_pkg::L_RECV && l.ph == clcd_pkg::PH_ADDR && next_l.st == clcd_pkg::L_ACK)
        |-> (l.shift[7:1] == own_addr && !l.shift[0]);
    endproperty
    a_addr_match: assert property (p_addr_match) else $error("ack on foreign address");

    property p_start;
        @(posedge LINK_CLK) disable iff (!link_rst_n)
        start_cond |=> (l.st == clcd_pkg::L_RECV && l.cnt == 4'h0 && !SDA_OE);
    endproperty
    a_start: assert property (p_start) else $error("start not taken");

    property p_stop;
        @(posedge LINK_CLK) disable iff (!link_rst_n)
        stop_cond |=> (l.st == clcd_pkg::L_IDLE && !SDA_OE);
    endproperty
    a_stop: assert property (p_stop) else $error("stop not taken");

    property p_bit;
        @(posedge LINK_CLK) disable iff (!link_rst_n)
        (l.st == clcd_pkg::L_RECV && scl_rise && l.cnt < 4'h8 && !start_cond && !stop_cond)
        |=> (l.cnt == $past(l.cnt) + 4'h1 && l.shift[0] == $past(sda));
    endproperty
    a_bit: assert property (p_bit) else $error("bit not shifted");

    property p_ack_high;
        @(posedge LINK_CLK) disable iff (!link_rst_n)
        (l.st == clcd_pkg::L_ACK && scl) |-> (SDA_OE && !SDA_O);
    endproperty
    a_ack_high: assert property (p_ack_high) else $error("ack not held");

    property p_ignore;
        @(posedge LINK_CLK) disable iff (!link_rst_n)
        (l.st == clcd_pkg::L_IGNORE) |-> !SDA_OE;
    endproperty
    a_ignore: assert property (p_ignore) else $error("drive while ignoring");

    property p_busy;
        @(posedge REF_CLK) disable iff (!core_rst_n)
        (c.st != clcd_pkg::C_READY) |-> BUSY_FLAG;
    endproperty
    a_busy: assert property (p_busy) else $error("busy low during work");

    property p_fill;
        @(posedge REF_CLK) disable iff (!core_rst_n)
        (c.st == clcd_pkg::C_INIT) |-> (ram_we && ram_wd == 8'h20 && DATA_LENGTH_BIT &&
                                        ENTRY_INCREMENT && !DISPLAY_ON && !ENTRY_SHIFT);
    endproperty
    a_fill: assert property (p_fill) else $error("init values wrong");

    property p_ptr_step;
        @(posedge REF_CLK) disable iff (!core_rst_n)
        (c.st == clcd_pkg::C_READY && new_byte && l.kind_out)
        |=> (ADDRESS_COUNTER == ($past(c.id) ? $past(c.ptr) + 7'h01 : $past(c.ptr) - 7'h01));
    endproperty
    a_ptr_step: assert property (p_ptr_step) else $error("pointer not stepped");

    c_start:  cover property (@(posedge LINK_CLK) disable iff (!link_rst_n) start_cond);
    c_addr:   cover property (@(posedge LINK_CLK) disable iff (!link_rst_n)
                              l.st == clcd_pkg::L_ACK && l.ph == clcd_pkg::PH_CTRL);
    c_ready:  cover property (@(posedge REF_CLK) disable iff (!core_rst_n) $fell(BUSY_FLAG));
    c_ramwr:  cover property (@(posedge REF_CLK) disable iff (!core_rst_n)
                              c.st == clcd_pkg::C_READY && ram_we);

endmodule : clcd_i2c_slave

/* dv/clcd_i2c_master.sv */
`timescale 1ns/1ps
// Bus master model; paces the serial clock from the core clock
module clcd_i2c_master (
    input  wire logic clk,     // Pacing clock
    input  wire logic sda,     // Resolved data line
    output logic      scl,     // Serial clock
    output logic      sda_low  // High while pulling data low
);
    // Idle bus: both lines high
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask : wt
    // Start only from an idle bus
    task automatic start();
        wt(4);
        sda_low = 1'b1;
        wt(8);
    endtask : start
    // Data moves only while clock low; ninth pulse left released
    task automatic put(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= -1; i--) begin
            scl = 1'b0;
            wt(2);
            sda_low = (i >= 0) ? ~b[i] : 1'b0;
            wt(6);
            scl = 1'b1;
            wt(4);
            ack = ~sda;
            wt(4);
        end
    endtask : put
    // Every transfer closes with a stop
    task automatic stop();
        scl = 1'b0;
        wt(2);
        sda_low = 1'b1;
        wt(6);
        scl = 1'b1;
        wt(8);
        sda_low = 1'b0;
    endtask : stop
endmodule : clcd_i2c_master

/* dv/clcd_i2c_slave_tb.sv */
`timescale 1ns/1ps
module clcd_i2c_slave_tb;
    logic       REF_CLK = 1'b0;
    logic       LINK_CLK = 1'b0;
    logic       ARST_N = 1'b0;
    logic [1:0] strap = 2'h0;
    logic [6:0] rd_addr = 7'h00;
    wire  [7:0] rd_data, cfg;
    wire  [6:0] ptr;
    wire        scl, m_low, sda_o, sda_oe, busy;
    wire        sda = ~(m_low | (sda_oe & ~sda_o)); // Pull-up wins when nobody pulls
    int         mismatches = 0;
    int         samples_checked = 0;
    integer     seed = 32'hDC9B3198;
    clcd_i2c_slave u_clcd_i2c_slave (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .LINK_CLK(LINK_CLK),
        .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe),
        .ADDR_SELECT_PIN_LOW(strap[0]), .ADDR_SELECT_PIN_HIGH(strap[1]),
        .DISP_RD_ADDR(rd_addr), .DISP_RD_DATA(rd_data), .BUSY_FLAG(busy),
        .ADDRESS_COUNTER(ptr), .DATA_LENGTH_BIT(cfg[7]), .LINE_COUNT(cfg[6]), .FONT(cfg[5]),
        .DISPLAY_ON(cfg[4]), .CURSOR_ON(cfg[3]), .BLINK_ON(cfg[2]),
        .ENTRY_INCREMENT(cfg[1]), .ENTRY_SHIFT(cfg[0]));
    clcd_i2c_master u_clcd_i2c_master (.clk(REF_CLK), .sda(sda), .scl(scl), .sda_low(m_low));
    // Core clock
    always #12.5 REF_CLK = ~REF_CLK;
    // Link clock, offset so its edges drift against the core clock
    initial begin
        #3.3;
        forever #7.5 LINK_CLK = ~LINK_CLK;
    end
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // One write transfer; all bytes acked, or all refused
    task automatic frame(input logic [7:0] q[$], input logic ok);
        logic a;
        u_clcd_i2c_master.start();
        foreach (q[i]) begin
            u_clcd_i2c_master.put(q[i], a);
            chk("ack", {7'h00, ok}, {7'h00, a});
        end
        u_clcd_i2c_master.stop();
    endtask : frame
    task automatic ram_chk(input logic [6:0] a, input logic [7:0] exp);
        rd_addr = a;
        repeat (2) @(negedge REF_CLK);
        chk("ram", exp, rd_data);
    endtask : ram_chk
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    // Watchdog, several times the expected run
    initial begin
        repeat (60000) @(posedge REF_CLK);
        mismatches++;
        summarize();
    end
    // Main sequence
    initial begin
        logic [7:0] w, d1, d2;
        logic [6:0] e;
        repeat (6) @(negedge REF_CLK);
        ARST_N = 1'b1;
        @(negedge REF_CLK);
        chk("busy", 8'h01, {7'h00, busy});
        chk("cfg", 8'h82, cfg);
        for (int k = 0; k < 400 && busy !== 1'b0; k++) @(negedge REF_CLK);
        chk("busy", 8'h00, {7'h00, busy});
        for (int k = 0; k < 4; k++) begin
            w = $random(seed);
            ram_chk(w[6:0], 8'h20);
        end
        $display("test init done");
        e = 7'h00;
        // Every strap setting against all four addresses; only a match moves the counter
        for (int s = 0; s < 4; s++) begin
            strap = s[1:0];
            for (int t = 0; t < 4; t++) begin
                w = $random(seed);
                frame('{8'h78 + 8'(2 * t), 8'h00, {1'b1, w[6:0]}}, s == t);
                if (s == t) e = w[6:0];
                chk("ptr", {1'b0, e}, {1'b0, ptr});
            end
        end
        // Read and foreign address refused; master leaves the line released and stops
        frame('{8'h7F, 8'h00, 8'h80}, 1'b0);
        frame('{8'h3E, 8'h00, 8'h80}, 1'b0);
        chk("ptr", {1'b0, e}, {1'b0, ptr});
        $display("test address done");
        d1 = $random(seed);
        d2 = $random(seed);
        frame('{8'h7E, 8'h40, d1, d2, 8'hC0}, 1'b1);
        ram_chk(e, d1);
        ram_chk(e + 7'h01, d2);
        ram_chk(e + 7'h02, 8'hC0);
        chk("ptr", {1'b0, e + 7'h03}, {1'b0, ptr});
        frame('{8'h7E, 8'h9F, 8'h05, 8'hC0, d1, 8'h40, d2}, 1'b1);
        ram_chk(e + 7'h03, d1);
        ram_chk(e + 7'h02, d2);
        chk("ptr", {1'b0, e + 7'h01}, {1'b0, ptr});
        $display("test stream done");
        // Line count and font set too, so every setting output but DATA_LENGTH_BIT leaves its reset value
        frame('{8'h7E, 8'h80, 8'h3C, 8'h00, 8'h0F}, 1'b1);
        chk("cfg", 8'hFD, cfg);
        $display("test settings done");
        // Clear instruction: busy again while the fill runs
        frame('{8'h7E, 8'h00, 8'h01}, 1'b1);
        chk("busy", 8'h01, {7'h00, busy});
        for (int k = 0; k < 400 && busy !== 1'b0; k++) @(negedge REF_CLK);
        chk("busy", 8'h00, {7'h00, busy});
        ram_chk(e, 8'h20);
        chk("ptr", 8'h00, {1'b0, ptr});
        chk("cfg", 8'hFF, cfg);
        // Glyph pointer, unstored glyph write, home, cursor shift left
        frame('{8'h7E, 8'h80, 8'h48, 8'hC0, 8'h5A, 8'h80, 8'h02, 8'h80, 8'h10}, 1'b1);
        ram_chk(7'h08, 8'h20);
        chk("ptr", 8'h7F, {1'b0, ptr});
        $display("test instructions done");
        summarize();
    end
endmodule : clcd_i2c_slave_tb
